// ### hw/tpou_group.sv
// One four-bit output group: trigger selection and transfer to the pins.
`timescale 1ns/1ps
module tpou_group (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration.
   input wire logic [1:0] trig_sel_i,
   input wire logic nov_i,
   input wire logic [3:0] en_i,
   input wire logic [3:0] nd_i,
   // Timer compare-match pulses, one per channel.
   input wire logic [3:0] cmp_a_i,
   input wire logic [3:0] cmp_b_i,
   // Pattern outputs.
   output logic [3:0] pins_o
);
   import tpou_pkg::*;

   wire match_a;
   wire match_b;
   wire [3:0] full_xfer;
   wire [3:0] fall_only;
   wire [3:0] next_pins;

   assign match_a = cmp_a_i[trig_sel_i];
   assign match_b = cmp_b_i[trig_sel_i];
   // Disabled bits keep their pin value; enabled bits take the next data.
   assign full_xfer = (en_i & nd_i) | (~en_i & pins_o);
   // Non-overlap: falling edges go at match A, rising edges wait for match B.
   assign fall_only = pins_o & ~(en_i & ~nd_i);
   assign next_pins = (nov_i && match_b) ? full_xfer : (match_a ? (nov_i ? fall_only : full_xfer) : pins_o);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pins_o <= TPOU_RST_PIN;
      end
      else
      begin
         pins_o <= next_pins;
      end
   end

   normal_xfer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!nov_i && match_a) |=> (((pins_o ^ $past(nd_i)) & $past(en_i)) == 4'h0))
      else $error("Enabled pin missed its next data at match A.");

   nov_no_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (nov_i && match_a && !match_b) |=> ((pins_o & ~$past(pins_o)) == 4'h0))
      else $error("Pin rose at match A in non-overlap mode.");

   nov_rise_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (nov_i && match_b) |=> (((pins_o ^ $past(nd_i)) & $past(en_i)) == 4'h0))
      else $error("Enabled pin missed its next data at match B.");

   disabled_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (((pins_o ^ $past(pins_o)) & ~$past(en_i)) == 4'h0))
      else $error("Disabled pin changed.");

   idle_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(match_a || (nov_i && match_b)) |=> $stable(pins_o))
      else $error("Pins changed without a trigger.");

endmodule : tpou_group

// ### hw/tpou_nibble.sv
// One four-bit next-data holding register.
`timescale 1ns/1ps
module tpou_nibble (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Write side.
   input wire logic we_i,
   input wire logic [3:0] wdata_i,
   // Stored value.
   output logic [3:0] q_o
);
   import tpou_pkg::*;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q_o <= TPOU_RST_ND;
      end
      else if (we_i)
      begin
         q_o <= wdata_i;
      end
   end

endmodule : tpou_nibble

// ### hw/tpou_top.sv
// Timed pattern output unit: register file on classic Wishbone and four output groups.
//
// Behaviour
// - Group 0 trigger field picks channel 0-3.
// - Group 1 trigger field picks channel 0-3.
// - Group 2 trigger field picks channel 0-3.
// - Group 3 trigger field picks channel 0-3.
// - Enable bit 0 blocks next data transfer.
// - Enable bit 1 transfers next data on trigger.
// - Shared trigger: one byte, companion reads ones.
// - Split trigger: nibbles at two addresses, rest ones.
// - Normal mode updates at selected compare match A.
// - Non-overlap mode uses compare match A and B.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tpou_top (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tpou_pkg::TPOU_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Timer compare-match pulses, one bit per channel.
   input wire logic [3:0] cmp_a_i,
   input wire logic [3:0] cmp_b_i,
   // Pattern pins and their per-bit drive enables.
   output logic [15:0] pattern_pin_o,
   output logic [15:0] pattern_drive_o
);
   import tpou_pkg::*;

   logic [7:0] trig_sel;
   logic [3:0] nov;
   logic [7:0] en_hi;
   logic [7:0] en_lo;
   logic [15:0] next_output_bit;
   logic [7:0] rd_byte;

   wire req;
   wire [7:0] idx;
   wire wr_fire;
   wire [7:0] wbyte;
   wire hit_nov;
   wire hit_trig;
   wire hit_en_hi;
   wire hit_en_lo;
   wire hit_hi_p;
   wire hit_lo_p;
   wire hit_hi_s;
   wire hit_lo_s;
   wire same_lo;
   wire same_hi;
   wire [1:0] sel_g0;
   wire [1:0] sel_g1;
   wire [1:0] sel_g2;
   wire [1:0] sel_g3;
   wire [3:0] nib_we;
   wire [15:0] nib_wd;
   wire [7:0] rd_lo_p;
   wire [7:0] rd_lo_s;
   wire [7:0] rd_hi_p;
   wire [7:0] rd_hi_s;
   wire [15:0] en_all;

   // Bus decode. Only byte lane 0 carries data; the upper lanes read as zero.
   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[TPOU_IDX_LSB +: 8];
   assign wbyte = wb_dat_i[7:0];
   // A write takes effect at the edge where the master sees ack.
   assign wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign hit_nov = (idx == TPOU_IDX_NOV);
   assign hit_trig = (idx == TPOU_IDX_TRIG);
   assign hit_en_hi = (idx == TPOU_IDX_EN_HI);
   assign hit_en_lo = (idx == TPOU_IDX_EN_LO);
   assign hit_hi_p = (idx == TPOU_IDX_ND_HI_P);
   assign hit_lo_p = (idx == TPOU_IDX_ND_LO_P);
   assign hit_hi_s = (idx == TPOU_IDX_ND_HI_S);
   assign hit_lo_s = (idx == TPOU_IDX_ND_LO_S);

   // Trigger fields per group.
   assign sel_g0 = trig_sel[TPOU_GRP0_SEL_LSB +: TPOU_SEL_W];
   assign sel_g1 = trig_sel[TPOU_GRP1_SEL_LSB +: TPOU_SEL_W];
   assign sel_g2 = trig_sel[TPOU_GRP2_SEL_LSB +: TPOU_SEL_W];
   assign sel_g3 = trig_sel[TPOU_GRP3_SEL_LSB +: TPOU_SEL_W];
   assign same_lo = (sel_g0 == sel_g1);
   assign same_hi = (sel_g2 == sel_g3);

   // Next-data write steering follows the trigger arrangement.
   assign nib_we[0] = wr_fire & (same_lo ? hit_lo_p : hit_lo_s);
   assign nib_we[1] = wr_fire & hit_lo_p;
   assign nib_we[2] = wr_fire & (same_hi ? hit_hi_p : hit_hi_s);
   assign nib_we[3] = wr_fire & hit_hi_p;
   assign nib_wd = {wbyte[7:4], wbyte[3:0], wbyte[7:4], wbyte[3:0]};

   // Next-data read images; positions not in use read as ones.
   assign rd_lo_p = same_lo ? next_output_bit[7:0] : {next_output_bit[7:4], TPOU_NIB_ONES};
   assign rd_lo_s = same_lo ? TPOU_BYTE_ONES : {TPOU_NIB_ONES, next_output_bit[3:0]};
   assign rd_hi_p = same_hi ? next_output_bit[15:8] : {next_output_bit[15:12], TPOU_NIB_ONES};
   assign rd_hi_s = same_hi ? TPOU_BYTE_ONES : {TPOU_NIB_ONES, next_output_bit[11:8]};

   assign en_all = {en_hi, en_lo};
   assign pattern_drive_o = en_all;

   always_comb
   begin
      if (hit_nov)
      begin
         rd_byte = {TPOU_NOV_RSV, nov};
      end
      else if (hit_trig)
      begin
         rd_byte = trig_sel;
      end
      else if (hit_en_hi)
      begin
         rd_byte = en_hi;
      end
      else if (hit_en_lo)
      begin
         rd_byte = en_lo;
      end
      else if (hit_hi_p)
      begin
         rd_byte = rd_hi_p;
      end
      else if (hit_lo_p)
      begin
         rd_byte = rd_lo_p;
      end
      else if (hit_hi_s)
      begin
         rd_byte = rd_hi_s;
      end
      else if (hit_lo_s)
      begin
         rd_byte = rd_lo_s;
      end
      else
      begin
         rd_byte = TPOU_UNMAPPED_RD;
      end
   end

   // Ack comes one cycle after the request and lasts one cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req && !wb_ack_o)
         begin
            wb_dat_o <= {TPOU_RD_PAD, rd_byte};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_sel <= TPOU_RST_TRIG;
         nov <= TPOU_RST_NOV;
         en_hi <= TPOU_RST_EN;
         en_lo <= TPOU_RST_EN;
      end
      else if (wr_fire)
      begin
         if (hit_trig)
         begin
            trig_sel <= wbyte;
         end
         if (hit_nov)
         begin
            nov <= wbyte[3:0];
         end
         if (hit_en_hi)
         begin
            en_hi <= wbyte;
         end
         if (hit_en_lo)
         begin
            en_lo <= wbyte;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < TPOU_NGRP; g++)
      begin : g_grp
         tpou_nibble u_nib (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .we_i(nib_we[g]),
            .wdata_i(nib_wd[4*g +: 4]),
            .q_o(next_output_bit[4*g +: 4])
         );
         tpou_group u_grp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .trig_sel_i(trig_sel[TPOU_SEL_W*g +: TPOU_SEL_W]),
            .nov_i(nov[g]),
            .en_i(en_all[4*g +: 4]),
            .nd_i(next_output_bit[4*g +: 4]),
            .cmp_a_i(cmp_a_i),
            .cmp_b_i(cmp_b_i),
            .pins_o(pattern_pin_o[4*g +: 4])
         );
      end
   endgenerate

   grp0_trigger_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!nov[0] && cmp_a_i[sel_g0])
      |=> (((pattern_pin_o[3:0] ^ $past(next_output_bit[3:0])) & $past(en_all[3:0])) == 4'h0))
      else $error("Group 0 did not follow its selected channel.");

   grp1_trigger_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!nov[1] && cmp_a_i[sel_g1])
      |=> (((pattern_pin_o[7:4] ^ $past(next_output_bit[7:4])) & $past(en_all[7:4])) == 4'h0))
      else $error("Group 1 did not follow its selected channel.");

   grp2_trigger_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!nov[2] && cmp_a_i[sel_g2])
      |=> (((pattern_pin_o[11:8] ^ $past(next_output_bit[11:8])) & $past(en_all[11:8])) == 4'h0))
      else $error("Group 2 did not follow its selected channel.");

   grp3_trigger_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!nov[3] && cmp_a_i[sel_g3])
      |=> (((pattern_pin_o[15:12] ^ $past(next_output_bit[15:12])) & $past(en_all[15:12])) == 4'h0))
      else $error("Group 3 did not follow its selected channel.");

   pin_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (((pattern_pin_o ^ $past(pattern_pin_o)) & ~$past(en_all)) == 16'h0000))
      else $error("A disabled pattern pin changed.");

   shared_companion_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_hi_s && same_hi) |=> (wb_dat_o == 32'h000000ff))
      else $error("Companion address did not read all ones.");

   shared_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_hi_p && same_hi) |=> (next_output_bit[15:8] == $past(wbyte)))
      else $error("Shared next-data byte not stored.");

   split_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_hi_p && !same_hi) |=> (wb_dat_o[3:0] == 4'hf))
      else $error("Unused lower nibble did not read ones.");

   split_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_hi_s && !same_hi) |=> (next_output_bit[11:8] == $past(wbyte[3:0])))
      else $error("Group 2 next data not stored at upper address.");

   unused_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_hi_s && same_hi) |=> $stable(next_output_bit[11:8]))
      else $error("Write to unused position changed next data.");

   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Ack was not a single cycle after the request.");

   unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && (idx < TPOU_IDX_NOV || idx > TPOU_IDX_ND_LO_S)) |=> (wb_dat_o == 32'h00000000))
      else $error("Unmapped address did not read zero.");

   // Register read-back, write steering, write timing and reset value checks.
   trig_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_trig) |=> (trig_sel == $past(wbyte)))
      else $error("Trigger select write not stored.");

   trig_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_trig) |=> (wb_dat_o == {TPOU_RD_PAD, $past(trig_sel)}))
      else $error("Trigger select did not read back.");

   en_hi_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_en_hi) |=> (en_hi == $past(wbyte)))
      else $error("High enable write not stored.");

   en_lo_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_en_lo) |=> (en_lo == $past(wbyte)))
      else $error("Low enable write not stored.");

   en_hi_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_en_hi) |=> (wb_dat_o[7:0] == $past(en_hi)))
      else $error("High enable did not read back.");

   en_lo_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_en_lo) |=> (wb_dat_o[7:0] == $past(en_lo)))
      else $error("Low enable did not read back.");

   nov_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_nov) |=> (nov == $past(wbyte[3:0])))
      else $error("Non-overlap write not stored.");

   nov_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_nov) |=> (wb_dat_o[7:0] == {TPOU_NOV_RSV, $past(nov)}))
      else $error("Non-overlap register did not read back.");

   shared_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_hi_p && same_hi) |=> (wb_dat_o[7:0] == $past(next_output_bit[15:8])))
      else $error("Shared next-data byte did not read back.");

   split_companion_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_hi_s && !same_hi) |=> (wb_dat_o[7:0] == {TPOU_NIB_ONES, $past(next_output_bit[11:8])}))
      else $error("Group 2 next data did not read at upper address.");

   split_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_hi_p && !same_hi) |=> ((next_output_bit[15:12] == $past(wbyte[7:4])) && $stable(next_output_bit[11:8])))
      else $error("Split write at lower address reached the wrong nibble.");

   split_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_hi_s && !same_hi) |=> $stable(next_output_bit[15:12]))
      else $error("Split write at upper address changed group 3 data.");

   lo_shared_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_lo_p && same_lo) |=> (next_output_bit[7:0] == $past(wbyte)))
      else $error("Shared low next-data byte not stored.");

   lo_companion_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_lo_s && same_lo) |=> (wb_dat_o[7:0] == TPOU_BYTE_ONES))
      else $error("Low companion address did not read all ones.");

   lo_split_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o && hit_lo_s && !same_lo) |=> (wb_dat_o[7:0] == {TPOU_NIB_ONES, $past(next_output_bit[3:0])}))
      else $error("Group 0 next data did not read at upper address.");

   lo_split_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && hit_lo_s && !same_lo) |=> ((next_output_bit[3:0] == $past(wbyte[3:0])) && $stable(next_output_bit[7:4])))
      else $error("Split low write reached the wrong nibble.");

   lane_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i && wb_ack_o && !wb_sel_i[0]) |=> ($stable(next_output_bit) && $stable(trig_sel) && $stable(en_all)))
      else $error("Write without lane 0 select changed a register.");

   late_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o) |=> ($stable(next_output_bit) && $stable(trig_sel) && $stable(en_all) && $stable(nov)))
      else $error("Write took effect before ack.");

   upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o[31:8] == TPOU_RD_PAD))
      else $error("Upper read lanes were not zero.");

   reset_values_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> ((trig_sel == TPOU_RST_TRIG) && (en_all == 16'h0000) && (next_output_bit == 16'h0000)))
      else $error("Registers did not hold their reset values.");

endmodule : tpou_top

// ### pkg/tpou_pkg.sv
// Shared constants for the timed pattern output unit.
package tpou_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] TPOU_IDX_NOV = 8'ha0;
   localparam logic [7:0] TPOU_IDX_TRIG = 8'ha1;
   localparam logic [7:0] TPOU_IDX_EN_HI = 8'ha2;
   localparam logic [7:0] TPOU_IDX_EN_LO = 8'ha3;
   localparam logic [7:0] TPOU_IDX_ND_HI_P = 8'ha4;
   localparam logic [7:0] TPOU_IDX_ND_LO_P = 8'ha5;
   localparam logic [7:0] TPOU_IDX_ND_HI_S = 8'ha6;
   localparam logic [7:0] TPOU_IDX_ND_LO_S = 8'ha7;

   // Bus geometry.
   localparam int unsigned TPOU_ADR_W = 10;
   localparam int unsigned TPOU_IDX_LSB = 2;

   // Field positions of the trigger-select fields, two bits per group.
   localparam int unsigned TPOU_GRP0_SEL_LSB = 0;
   localparam int unsigned TPOU_GRP1_SEL_LSB = 2;
   localparam int unsigned TPOU_GRP2_SEL_LSB = 4;
   localparam int unsigned TPOU_GRP3_SEL_LSB = 6;
   localparam int unsigned TPOU_SEL_W = 2;
   localparam int unsigned TPOU_NGRP = 4;
   localparam int unsigned TPOU_NCH = 4;

   // Reset values.
   localparam logic [7:0] TPOU_RST_TRIG = 8'hff;
   localparam logic [3:0] TPOU_RST_NOV = 4'h0;
   localparam logic [7:0] TPOU_RST_EN = 8'h00;
   localparam logic [3:0] TPOU_RST_ND = 4'h0;
   localparam logic [3:0] TPOU_RST_PIN = 4'h0;

   // Read values of unused positions.
   localparam logic [3:0] TPOU_NOV_RSV = 4'hf;
   localparam logic [3:0] TPOU_NIB_ONES = 4'hf;
   localparam logic [7:0] TPOU_BYTE_ONES = 8'hff;
   localparam logic [7:0] TPOU_UNMAPPED_RD = 8'h00;
   localparam logic [23:0] TPOU_RD_PAD = 24'h000000;

endpackage : tpou_pkg

// ### verification/timed_pattern_output_regs_tb.sv
// Self-checking testbench for the timed pattern output unit.
`timescale 1ns/1ps
module timed_pattern_output_regs_tb;
   import tpou_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0] wb_adr_i;
   logic [3:0] wb_sel_i, cmp_a_i, cmp_b_i, nov;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] pattern_pin_o, pattern_drive_o, nd, en, pins;
   logic [7:0] trig;
   logic [31:0] exp_rd[$];
   int n_errors = 0;
   int total_checks = 0;

   tpou_top tpou_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_a_i(cmp_a_i), .cmp_b_i(cmp_b_i),
      .pattern_pin_o(pattern_pin_o), .pattern_drive_o(pattern_drive_o));
   tpou_timer_model tpou_timer_model_i (.clk_i(clk_i), .cmp_a_o(cmp_a_i), .cmp_b_o(cmp_b_i));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic final_report;
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic chk_read(input logic [31:0] e);
      chk("read data", e, wb_dat_o);
   endtask : chk_read

   task automatic chk_pins(input logic [15:0] e);
      chk("pins", {16'h0000, e}, {16'h0000, pattern_pin_o});
   endtask : chk_pins

   task automatic chk_drive(input logic [15:0] e);
      chk("drive", {16'h0000, e}, {16'h0000, pattern_drive_o});
   endtask : chk_drive

   // Read data is compared with the oldest note at the edge where ack is sampled.
   always @(posedge clk_i)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_rd.size() > 0)
         chk_read(exp_rd.pop_front());

   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {24'h000000, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         n_errors++;
         $display("Error bus ack expected 1 seen %b", wb_ack_o);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_rd.push_back({24'h000000, e});
      wb(1'b0, idx, 8'h00, 4'h1);
   endtask : rd

   function automatic logic [3:0] nxt(input logic [3:0] p, d, e, input logic nv, a, b);
      logic [3:0] t;
      if (nv && a && !b)
         t = p & d;
      else if (b || (a && !nv))
         t = b && !a && !nv ? p : d;
      else
         t = p;
      return (t & e) | (p & ~e);
   endfunction : nxt

   // Works out the expected pins, fires the timer, then lets the pins settle.
   task automatic fire(input logic [3:0] a, input logic [3:0] b);
      logic [1:0] s;
      for (int g = 0; g < 4; g++)
      begin
         s = trig[2*g+:2];
         pins[4*g+:4] = nxt(pins[4*g+:4], nd[4*g+:4], en[4*g+:4], nov[g], a[s], b[s]);
      end
      tpou_timer_model_i.fire(a, b);
      @(posedge clk_i);
      chk_pins(pins);
   endtask : fire

   initial
   begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      $display("Error watchdog expected done seen hang");
      final_report;
   end

   initial
   begin
      void'($urandom(32'hdf42));
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      rst_i = 1'b1;
      {pins, nd, en, nov} = '0;
      trig = TPOU_RST_TRIG;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(TPOU_IDX_EN_HI, TPOU_RST_EN);
      rd(TPOU_IDX_EN_LO, TPOU_RST_EN);
      rd(TPOU_IDX_ND_HI_P, 8'h00);
      rd(TPOU_IDX_ND_HI_S, 8'hff);
      rd(TPOU_IDX_TRIG, 8'hff);
      rd(8'h10, TPOU_UNMAPPED_RD);
      wb(1'b1, TPOU_IDX_ND_HI_P, 8'h5a, 4'h0);
      rd(TPOU_IDX_ND_HI_P, 8'h00);
      wr(TPOU_IDX_ND_HI_S, 8'h3c);
      rd(TPOU_IDX_ND_HI_S, 8'hff);
      repeat (10)
      begin
         wr(TPOU_IDX_TRIG, 8'hff);
         nd = 16'($urandom);
         en = 16'($urandom);
         nov = 4'($urandom);
         trig = 8'($urandom);
         wr(TPOU_IDX_ND_HI_P, nd[15:8]);
         wr(TPOU_IDX_ND_LO_P, nd[7:0]);
         rd(TPOU_IDX_ND_HI_P, nd[15:8]);
         wr(TPOU_IDX_EN_HI, en[15:8]);
         wr(TPOU_IDX_EN_LO, en[7:0]);
         wr(TPOU_IDX_NOV, {4'h0, nov});
         rd(TPOU_IDX_NOV, {4'hf, nov});
         wr(TPOU_IDX_TRIG, trig);
         rd(TPOU_IDX_TRIG, trig);
         if (trig[5:4] != trig[7:6])
         begin
            wr(TPOU_IDX_ND_HI_P, {nd[15:12], ~nd[11:8]});
            wr(TPOU_IDX_ND_HI_S, {~nd[15:12], nd[11:8]});
            rd(TPOU_IDX_ND_HI_P, {nd[15:12], 4'hf});
            rd(TPOU_IDX_ND_HI_S, {4'hf, nd[11:8]});
         end
         if (trig[1:0] != trig[3:2])
         begin
            wr(TPOU_IDX_ND_LO_P, {nd[7:4], ~nd[3:0]});
            wr(TPOU_IDX_ND_LO_S, {~nd[7:4], nd[3:0]});
            rd(TPOU_IDX_ND_LO_P, {nd[7:4], 4'hf});
            rd(TPOU_IDX_ND_LO_S, {4'hf, nd[3:0]});
         end
         chk_drive(en);
         for (int ch = 0; ch < 4; ch++)
         begin
            fire(4'h0, 4'(1 << ch));
            fire(4'(1 << ch), 4'h0);
         end
         fire(4'hf, 4'hf);
      end
      final_report;
   end
endmodule : timed_pattern_output_regs_tb

// ### verification/tpou_timer_model.sv
// Behavioural timer channels that raise compare-match pulses on request.
`timescale 1ns/1ps
module tpou_timer_model (
   // Clock.
   input wire logic clk_i,
   // Compare-match pulses, one bit per channel.
   output logic [3:0] cmp_a_o,
   output logic [3:0] cmp_b_o
);
   initial
   begin
      cmp_a_o = 4'h0;
      cmp_b_o = 4'h0;
   end

   // Raises the chosen matches for exactly one cycle, as a real timer does.
   task automatic fire(input logic [3:0] a, input logic [3:0] b);
      @(posedge clk_i);
      cmp_a_o <= a;
      cmp_b_o <= b;
      @(posedge clk_i);
      cmp_a_o <= 4'h0;
      cmp_b_o <= 4'h0;
   endtask : fire
endmodule : tpou_timer_model
